// ===== src/pio_relay_pkg.sv
// Shared constants and command codes for the port and crosspoint controller
package pio_relay_pkg;

  // ------------------------------------------------------------------
  // Widths and ranges
  // ------------------------------------------------------------------
  localparam int unsigned LINE_N    = 8;
  localparam int unsigned CHAN_N    = 32;
  localparam int unsigned BUSL_N    = 16;
  localparam int unsigned XPT_N     = CHAN_N * BUSL_N;
  localparam int unsigned IDX_W     = 8;
  localparam int unsigned CHAN_W    = 5;
  localparam int unsigned BUSL_W    = 4;
  localparam int unsigned XPT_W     = CHAN_W + BUSL_W;

  localparam logic [IDX_W-1:0] CHAN_LIMIT = 8'h20;
  localparam logic [IDX_W-1:0] BUSL_LIMIT = 8'h10;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [LINE_N-1:0] LEVEL_RST  = 8'h00;
  localparam logic [LINE_N-1:0] ENABLE_RST = 8'h00;
  localparam logic [LINE_N-1:0] SAMPLE_RST = 8'h00;
  localparam logic [XPT_N-1:0]  XPT_RST    = '0;

  // ------------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_SET_LEVEL   = 4'h1,
    CMD_GET_LEVEL   = 4'h2,
    CMD_SET_ENABLE  = 4'h3,
    CMD_GET_ENABLE  = 4'h4,
    CMD_READ_INPUT  = 4'h5,
    CMD_BOARD_RESET = 4'h6,
    CMD_XPT_CLOSE   = 4'h7,
    CMD_XPT_OPEN    = 4'h8,
    CMD_XPT_QUERY   = 4'h9
  } cmd_t;

endpackage : pio_relay_pkg

// ===== src/pio_relay_ctrl.sv
// Programmable I/O port and rear crosspoint relay controller
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Eight-bit drive level register sets each port line's driven level.
// - Eight-bit enable register turns each line's driver on or leaves it floating.
// - Reading the enable control returns the eight enable bits held.
// - Port lines are sampled into a register; a read returns the latest sample.
// - Enable bit one drives its line; all ones in both drive all lines high.
// - Board reset opens mux, matrix, rear module and switch router relays.
// - One crosspoint relay per channel 0-31 and bus line 0-15; close closes it.
// - Open command opens only the addressed crosspoint relay.
// - Query reports whether the addressed crosspoint relay is open or closed.
module pio_relay_ctrl
  import pio_relay_pkg::*;
(
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst_n,
  input  wire logic                                    cmd_valid,
  input  wire pio_relay_pkg::cmd_t                     cmd_code,
  input  wire logic [pio_relay_pkg::LINE_N-1:0]        cmd_data,
  input  wire logic [pio_relay_pkg::IDX_W-1:0]         instrument_channel_index,
  input  wire logic [pio_relay_pkg::IDX_W-1:0]         backplane_line_index,
  input  wire logic [pio_relay_pkg::LINE_N-1:0]        pio_line_i,
  output logic [pio_relay_pkg::LINE_N-1:0]             pio_line_o,
  output logic [pio_relay_pkg::LINE_N-1:0]             pio_line_oe,
  output logic                                         rsp_valid,
  output logic                                         rsp_error,
  output logic [pio_relay_pkg::LINE_N-1:0]             rsp_data,
  output logic                                         relay_closed_state,
  output logic [pio_relay_pkg::XPT_N-1:0]              crosspoint_closed,
  output logic                                         board_relays_open,
  output logic                                         switch_router_open
);
  import pio_relay_pkg::*;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  logic [LINE_N-1:0] line_drive_level_bits_reg;
  logic [LINE_N-1:0] line_drive_enable_bits_reg;
  logic [LINE_N-1:0] sync1_reg;
  logic [LINE_N-1:0] sync2_reg;
  logic [LINE_N-1:0] sampled_line_bits_reg;
  logic              idx_ok;
  logic              known_cmd;
  logic              xpt_cmd;
  logic [XPT_W-1:0]  xpt_sel;

  assign idx_ok  = (instrument_channel_index < CHAN_LIMIT)
                && (backplane_line_index < BUSL_LIMIT);
  assign xpt_sel = {instrument_channel_index[CHAN_W-1:0], backplane_line_index[BUSL_W-1:0]};
  assign xpt_cmd = (cmd_code == CMD_XPT_CLOSE) || (cmd_code == CMD_XPT_OPEN)
                || (cmd_code == CMD_XPT_QUERY);

  always_comb begin
    unique case (cmd_code)
      CMD_SET_LEVEL, CMD_GET_LEVEL, CMD_SET_ENABLE, CMD_GET_ENABLE, CMD_READ_INPUT,
      CMD_BOARD_RESET, CMD_XPT_CLOSE, CMD_XPT_OPEN, CMD_XPT_QUERY: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Port registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_drive_level_bits_reg <= LEVEL_RST;
    end else if (cmd_valid && cmd_code == CMD_SET_LEVEL) begin
      line_drive_level_bits_reg <= cmd_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_drive_enable_bits_reg <= ENABLE_RST;
    end else if (cmd_valid && cmd_code == CMD_SET_ENABLE) begin
      line_drive_enable_bits_reg <= cmd_data;
    end
  end

  // Pins follow the registers one cycle later so every output is a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pio_line_o  <= LEVEL_RST;
      pio_line_oe <= ENABLE_RST;
    end else begin
      pio_line_o  <= line_drive_level_bits_reg;
      pio_line_oe <= line_drive_enable_bits_reg;
    end
  end

  // Lines are asynchronous to clk_sys; sample after two stages
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg             <= SAMPLE_RST;
      sync2_reg             <= SAMPLE_RST;
      sampled_line_bits_reg <= SAMPLE_RST;
    end else begin
      sync1_reg             <= pio_line_i;
      sync2_reg             <= sync1_reg;
      sampled_line_bits_reg <= sync2_reg;
    end
  end

  // ------------------------------------------------------------------
  // Crosspoint relays
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crosspoint_closed <= XPT_RST;
    end else if (cmd_valid) begin
      if (cmd_code == CMD_BOARD_RESET) begin
        crosspoint_closed <= XPT_RST;
      end else if (idx_ok && cmd_code == CMD_XPT_CLOSE) begin
        crosspoint_closed[xpt_sel] <= 1'b1;
      end else if (idx_ok && cmd_code == CMD_XPT_OPEN) begin
        crosspoint_closed[xpt_sel] <= 1'b0;
      end
    end
  end

  // Mux/matrix and switch router relays live elsewhere; they get an open-all pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      board_relays_open  <= 1'b0;
      switch_router_open <= 1'b0;
    end else begin
      board_relays_open  <= cmd_valid && cmd_code == CMD_BOARD_RESET;
      switch_router_open <= cmd_valid && cmd_code == CMD_BOARD_RESET;
    end
  end

  // ------------------------------------------------------------------
  // Answers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_error <= cmd_valid && (!known_cmd || (xpt_cmd && !idx_ok));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_data <= '0;
    end else if (cmd_valid) begin
      unique case (cmd_code)
        CMD_GET_LEVEL:  rsp_data <= line_drive_level_bits_reg;
        CMD_GET_ENABLE: rsp_data <= line_drive_enable_bits_reg;
        CMD_READ_INPUT: rsp_data <= sampled_line_bits_reg;
        default:        rsp_data <= '0;
      endcase
    end
  end

  // The query sees state before any command in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      relay_closed_state <= 1'b0;
    end else if (cmd_valid && cmd_code == CMD_XPT_QUERY) begin
      relay_closed_state <= idx_ok && crosspoint_closed[xpt_sel];
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_set_all_high;
    cmd_valid && cmd_code == CMD_SET_ENABLE && cmd_data == 8'hff
    ##1 cmd_valid && cmd_code == CMD_SET_LEVEL && cmd_data == 8'hff;
  endsequence

  property p_level_write;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_SET_LEVEL |-> ##2 pio_line_o == $past(cmd_data, 2);
  endproperty
  a_level_write: assert property (p_level_write) else $error("drive level not applied");

  property p_enable_write;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_SET_ENABLE |-> ##2 pio_line_oe == $past(cmd_data, 2);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not applied");

  property p_enable_read;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_GET_ENABLE |=> rsp_valid && rsp_data == pio_line_oe;
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable readback wrong");

  property p_input_read;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_READ_INPUT |=> rsp_data == $past(sync2_reg, 2);
  endproperty
  a_input_read: assert property (p_input_read) else $error("sample readback wrong");

  property p_all_high;
    @(posedge clk_sys) disable iff (!rst_n)
      s_set_all_high |-> ##2 (pio_line_o == 8'hff && pio_line_oe == 8'hff);
  endproperty
  a_all_high: assert property (p_all_high) else $error("lines not all driven high");

  property p_board_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_BOARD_RESET
      |=> crosspoint_closed == '0 && board_relays_open && switch_router_open;
  endproperty
  a_board_reset: assert property (p_board_reset) else $error("board reset left relays");

  property p_close;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_XPT_CLOSE && idx_ok |=> crosspoint_closed[$past(xpt_sel)];
  endproperty
  a_close: assert property (p_close) else $error("crosspoint did not close");

  property p_open_only;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_XPT_OPEN && idx_ok
      |=> !crosspoint_closed[$past(xpt_sel)]
          && (crosspoint_closed | (XPT_N'(1) << $past(xpt_sel)))
             == ($past(crosspoint_closed) | (XPT_N'(1) << $past(xpt_sel)));
  endproperty
  a_open_only: assert property (p_open_only) else $error("open touched other relays");

  property p_query;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_XPT_QUERY && idx_ok
      |=> relay_closed_state == $past(crosspoint_closed[xpt_sel]);
  endproperty
  a_query: assert property (p_query) else $error("query state wrong");

  property p_reject;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_valid && xpt_cmd && !idx_ok |=> rsp_error && $stable(crosspoint_closed);
  endproperty
  a_reject: assert property (p_reject) else $error("bad index not rejected");

endmodule : pio_relay_ctrl

`default_nettype wire

// ===== test/line_partner.sv
// External line model that drives the port pins wherever the block floats them
`timescale 1ns/10ps
`default_nettype none

module line_partner
  import pio_relay_pkg::*;
(
  input  wire logic [pio_relay_pkg::LINE_N-1:0] pio_line_o,
  input  wire logic [pio_relay_pkg::LINE_N-1:0] pio_line_oe,
  input  wire logic [pio_relay_pkg::LINE_N-1:0] ext_level,
  output logic      [pio_relay_pkg::LINE_N-1:0] pio_line_i
);
  // Resolved wire per line: the block wins where its driver is on,
  // so a floating line shows the outside level, never a stale value
  always_comb begin
    for (int i = 0; i < LINE_N; i++) begin
      pio_line_i[i] = pio_line_oe[i] ? pio_line_o[i] : ext_level[i];
    end
  end
endmodule : line_partner

`default_nettype wire

// ===== test/pio_and_relay_matrix_control_tb.sv
// Self-checking bench for the port and crosspoint controller
`timescale 1ns/10ps
`default_nettype none

module pio_and_relay_matrix_control_tb;
  import pio_relay_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               cmd_valid = 1'b0;
  cmd_t               cmd_code = CMD_GET_LEVEL;
  logic [7:0]         cmd_data = 8'h00;
  logic [7:0]         instrument_channel_index = 8'h00;
  logic [7:0]         backplane_line_index = 8'h00;
  logic [7:0]         ext_level = 8'h00;
  logic [7:0]         pio_line_i, pio_line_o, pio_line_oe, rsp_data, got_data;
  logic               rsp_valid, rsp_error, relay_closed_state, got_err, got_state;
  logic               board_relays_open, switch_router_open, got_brd, got_sr;
  logic [XPT_N-1:0]   crosspoint_closed;
  logic [XPT_N-1:0]   xpt_exp = '0;
  int                 bad_count = 0;
  int                 checks_done = 0;

  always #25 clk_sys = ~clk_sys;

  pio_relay_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data),
    .instrument_channel_index(instrument_channel_index),
    .backplane_line_index(backplane_line_index), .pio_line_i(pio_line_i),
    .pio_line_o(pio_line_o), .pio_line_oe(pio_line_oe), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_data(rsp_data), .relay_closed_state(relay_closed_state),
    .crosspoint_closed(crosspoint_closed), .board_relays_open(board_relays_open),
    .switch_router_open(switch_router_open));

  line_partner far_side (.pio_line_o(pio_line_o), .pio_line_oe(pio_line_oe),
    .ext_level(ext_level), .pio_line_i(pio_line_i));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic issue(input cmd_t code, input logic [7:0] d, ch, bl);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_data = d;
    instrument_channel_index = ch;
    backplane_line_index = bl;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (int i = 0; i < 4 && rsp_valid !== 1'b1; i++) @(negedge clk_sys);
    check("rsp_valid", rsp_valid, 1'b1);
    got_err = rsp_error;
    got_data = rsp_data;
    got_state = relay_closed_state;
    got_brd = board_relays_open;
    got_sr = switch_router_open;
  endtask : issue

  task automatic xpt_cmd(input cmd_t code, input int ch, bl, input logic err);
    issue(code, 8'h00, 8'(ch), 8'(bl));
    check("rsp_error", got_err, err);
    if (!err && code == CMD_XPT_CLOSE) xpt_exp[ch*16+bl] = 1'b1;
    if (!err && code == CMD_XPT_OPEN) xpt_exp[ch*16+bl] = 1'b0;
    check("crosspoint_closed", crosspoint_closed === xpt_exp, 1'b1);
  endtask : xpt_cmd

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_drive_all();
    // Enable then level on consecutive edges, as software would write them
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code = CMD_SET_ENABLE;
    cmd_data = 8'hff;
    @(negedge clk_sys);
    cmd_code = CMD_SET_LEVEL;
    check("rsp_valid", rsp_valid, 1'b1);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    check("rsp_valid", rsp_valid, 1'b1);
    issue(CMD_GET_ENABLE, 8'h00, 8'h00, 8'h00);
    check("enable_read", got_data, 8'hff);
    issue(CMD_GET_LEVEL, 8'h00, 8'h00, 8'h00);
    check("level_read", got_data, 8'hff);
    repeat (6) @(negedge clk_sys);
    check("pio_line_o", pio_line_o, 8'hff);
    check("pio_line_oe", pio_line_oe, 8'hff);
    issue(CMD_READ_INPUT, 8'h00, 8'h00, 8'h00);
    check("input_read", got_data, 8'hff);
  endtask : t_drive_all

  task automatic t_partial();
    ext_level = 8'h3c;
    issue(CMD_SET_ENABLE, 8'h0f, 8'h00, 8'h00);
    issue(CMD_SET_LEVEL, 8'ha5, 8'h00, 8'h00);
    repeat (6) @(negedge clk_sys);
    check("pio_line_oe", pio_line_oe, 8'h0f);
    check("pio_line_o", pio_line_o, 8'ha5);
    issue(CMD_READ_INPUT, 8'h00, 8'h00, 8'h00);
    check("input_read", got_data, 8'h35);
    issue(CMD_GET_ENABLE, 8'h00, 8'h00, 8'h00);
    check("enable_read", got_data, 8'h0f);
  endtask : t_partial

  task automatic t_crosspoint();
    xpt_cmd(CMD_XPT_CLOSE, 31, 15, 1'b0);
    xpt_cmd(CMD_XPT_CLOSE, 0, 0, 1'b0);
    xpt_cmd(CMD_XPT_CLOSE, 5, 15, 1'b0);
    xpt_cmd(CMD_XPT_QUERY, 31, 15, 1'b0);
    check("query", got_state, 1'b1);
    xpt_cmd(CMD_XPT_OPEN, 31, 15, 1'b0);
    xpt_cmd(CMD_XPT_QUERY, 31, 15, 1'b0);
    check("query", got_state, 1'b0);
    xpt_cmd(CMD_XPT_CLOSE, 32, 0, 1'b1);
    xpt_cmd(CMD_XPT_OPEN, 0, 16, 1'b1);
    xpt_cmd(CMD_XPT_CLOSE, 255, 255, 1'b1);
    xpt_cmd(CMD_XPT_QUERY, 40, 0, 1'b1);
    check("query_bad_index", got_state, 1'b0);
    // An undefined command code must be refused and leave every relay alone
    xpt_cmd(cmd_t'(4'hf), 0, 0, 1'b1);
    xpt_cmd(CMD_XPT_QUERY, 0, 0, 1'b0);
    check("query", got_state, 1'b1);
  endtask : t_crosspoint

  task automatic t_board_reset();
    issue(CMD_BOARD_RESET, 8'h00, 8'h00, 8'h00);
    check("board_relays_open", got_brd, 1'b1);
    check("switch_router_open", got_sr, 1'b1);
    check("crosspoint_zero", crosspoint_closed === '0, 1'b1);
    @(negedge clk_sys);
    check("board_relays_open", board_relays_open, 1'b0);
    check("pio_line_oe", pio_line_oe, 8'h0f);
  endtask : t_board_reset

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk_sys);
    check("reset_oe", pio_line_oe, 8'h00);
    check("reset_xpt", crosspoint_closed === '0, 1'b1);
    rst_n = 1'b1;
    t_drive_all();
    t_partial();
    t_crosspoint();
    t_board_reset();
    complete_run();
  end

  initial begin
    #(50 * 5000);
    bad_count++;
    complete_run();
  end
endmodule : pio_and_relay_matrix_control_tb

`default_nettype wire
